// File: design/fan_zone_thermal_limits.sv
// fan_zone_thermal_limits: limit, margin and test registers for three fan zones
// assumes an internal register port from the management bus slave, lock and start
// bits from the lock/start register, and zone temperatures from the monitor
`timescale 1ns/1ps
`default_nettype none

module fan_zone_thermal_limits
    import fztl_pkg::*;
#(
    parameter int unsigned NUM_TEST_PINS = 16
)
(
    input  wire logic                     clk_sys,
    input  wire logic                     resetn,
    input  wire logic                     clkEn,
    input  wire logic [7:0]               regAddr,
    input  wire logic                     regWrEn,
    input  wire logic [7:0]               regWrData,
    input  wire logic                     regRdEn,
    output logic      [7:0]               regRdData,
    input  wire logic                     lockIn,
    input  wire logic                     startIn,
    input  wire logic                     autoFanMode,
    input  wire logic [7:0]               zoneTemp1,
    input  wire logic [7:0]               zoneTemp2,
    input  wire logic [7:0]               zoneTemp3,
    input  wire logic [NUM_TEST_PINS-1:0] testPins,
    output logic      [2:0]               fanOn,
    output logic      [2:0]               fanRampUp,
    output logic      [2:0]               fanHoldMin,
    output logic      [2:0]               zoneOverTemp,
    output logic                          forceFullDuty,
    output logic                          xorTestMode,
    output logic                          xorTreeOut
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    generate
        if (NUM_TEST_PINS < 1) begin : g_bad_pins
            $error("fan_zone_thermal_limits needs at least one test pin");
        end
    endgenerate

    // ************************************************************
    // storage
    // ************************************************************
    logic [7:0] onLimit_q   [NUM_ZONES];
    logic [7:0] fullLimit_q [NUM_ZONES];
    logic [7:0] margin12_q;
    logic [3:0] margin3_q;
    logic       xorTreeEnable_q;
    logic       lockSticky_q;
    logic [7:0] regRdData_q;
    logic       forceFullDuty_q;

    logic [7:0] zoneTemp  [NUM_ZONES];
    logic [7:0] effOn     [NUM_ZONES];
    logic [7:0] effFull   [NUM_ZONES];
    logic [3:0] rawMargin [NUM_ZONES];
    logic [3:0] effMargin [NUM_ZONES];

    assign zoneTemp[0] = zoneTemp1;
    assign zoneTemp[1] = zoneTemp2;
    assign zoneTemp[2] = zoneTemp3;

    // ************************************************************
    // lock capture
    // ************************************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lockSticky_q <= 1'b0;
        end else if (clkEn) begin
            lockSticky_q <= lockSticky_q | lockIn;
        end
    end

    wire logic locked = lockSticky_q | lockIn;
    wire logic wrOk   = regWrEn & ~locked;

    // ************************************************************
    // write decode
    // ************************************************************
    wire logic wrMargin12 = wrOk && (regAddr == OFS_ZONE12_TURNOFF_MARGIN);
    wire logic wrMargin3  = wrOk && (regAddr == OFS_ZONE3_TURNOFF_MARGIN);
    wire logic wrTest     = wrOk && (regAddr == OFS_SCAN_TEST_CONTROL);
    wire logic wrXen      = regWrData[XOR_TREE_ENABLE_BIT];

    genvar gz;
    generate
        for (gz = 0; gz < NUM_ZONES; gz++) begin : g_zone
            wire logic wrOn   = wrOk && (regAddr == OFS_ZONE1_FAN_ON_LIMIT + 8'(gz));
            wire logic wrFull = wrOk && (regAddr == OFS_ZONE1_FULL_SPEED_LIMIT + 8'(gz));

            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    onLimit_q[gz]   <= RST_FAN_ON_LIMIT;
                    fullLimit_q[gz] <= RST_FULL_SPEED_LIMIT;
                end else if (clkEn) begin
                    if (wrOn) begin
                        onLimit_q[gz] <= regWrData;
                    end
                    if (wrFull) begin
                        fullLimit_q[gz] <= regWrData;
                    end
                end
            end

            // control sees reset values until start is set
            assign effOn[gz]   = startIn ? onLimit_q[gz] : RST_FAN_ON_LIMIT;
            assign effFull[gz] = startIn ? fullLimit_q[gz] : RST_FULL_SPEED_LIMIT;
            assign effMargin[gz] = startIn ? rawMargin[gz] :
                (gz == 0) ? RST_ZONE12_MARGIN[ZONE1_MARGIN_LSB +: MARGIN_WIDTH] :
                (gz == 1) ? RST_ZONE12_MARGIN[ZONE2_MARGIN_LSB +: MARGIN_WIDTH] :
                            RST_ZONE3_MARGIN[ZONE3_MARGIN_LSB +: MARGIN_WIDTH];

            fztl_zone u_zone (
                .clk_sys   (clk_sys),
                .resetn    (resetn),
                .clkEn     (clkEn),
                .zoneTemp  (zoneTemp[gz]),
                .onLimit   (effOn[gz]),
                .fullLimit (effFull[gz]),
                .margin    (effMargin[gz]),
                .fanOn     (fanOn[gz]),
                .rampUp    (fanRampUp[gz]),
                .holdMin   (fanHoldMin[gz]),
                .overTemp  (zoneOverTemp[gz])
            );
        end
    endgenerate

    // ************************************************************
    // margin and test registers
    // ************************************************************
    assign rawMargin[0] = margin12_q[ZONE1_MARGIN_LSB +: MARGIN_WIDTH];
    assign rawMargin[1] = margin12_q[ZONE2_MARGIN_LSB +: MARGIN_WIDTH];
    assign rawMargin[2] = margin3_q;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            margin12_q      <= RST_ZONE12_MARGIN;
            margin3_q       <= RST_ZONE3_MARGIN[ZONE3_MARGIN_LSB +: MARGIN_WIDTH];
            xorTreeEnable_q <= RST_SCAN_TEST[XOR_TREE_ENABLE_BIT];
        end else if (clkEn) begin
            if (wrMargin12) begin
                margin12_q <= regWrData;
            end
            if (wrMargin3) begin
                margin3_q <= regWrData[ZONE3_MARGIN_LSB +: MARGIN_WIDTH];
            end
            if (wrTest) begin
                xorTreeEnable_q <= wrXen;
            end
        end
    end

    wire logic effXen = startIn & xorTreeEnable_q;

    // ************************************************************
    // read path
    // ************************************************************
    wire logic [7:0] margin3Read = {margin3_q, 4'h0};
    wire logic [7:0] testRead    = {7'h00, xorTreeEnable_q};
    logic      [7:0] rdMux;

    always_comb begin
        case (regAddr)
            OFS_ZONE1_FAN_ON_LIMIT:     rdMux = onLimit_q[0];
            OFS_ZONE2_FAN_ON_LIMIT:     rdMux = onLimit_q[1];
            OFS_ZONE3_FAN_ON_LIMIT:     rdMux = onLimit_q[2];
            OFS_ZONE1_FULL_SPEED_LIMIT: rdMux = fullLimit_q[0];
            OFS_ZONE2_FULL_SPEED_LIMIT: rdMux = fullLimit_q[1];
            OFS_ZONE3_FULL_SPEED_LIMIT: rdMux = fullLimit_q[2];
            OFS_ZONE12_TURNOFF_MARGIN:  rdMux = margin12_q;
            OFS_ZONE3_TURNOFF_MARGIN:   rdMux = margin3Read;
            OFS_SCAN_TEST_CONTROL:      rdMux = testRead;
            default:                    rdMux = READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            regRdData_q <= READ_UNMAPPED;
        end else if (clkEn && regRdEn) begin
            regRdData_q <= rdMux;
        end
    end

    // ************************************************************
    // full duty override
    // ************************************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            forceFullDuty_q <= 1'b0;
        end else if (clkEn) begin
            forceFullDuty_q <= autoFanMode & (|zoneOverTemp);
        end
    end

    // ************************************************************
    // xor test tree
    // ************************************************************
    fztl_xor_tree #(
        .NUM_TEST_PINS (NUM_TEST_PINS)
    ) u_xor_tree (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .clkEn      (clkEn),
        .treeEnable (effXen),
        .testPins   (testPins),
        .treeOut    (xorTreeOut)
    );

    assign regRdData     = regRdData_q;
    assign forceFullDuty = forceFullDuty_q;
    assign xorTestMode   = effXen;

    // ************************************************************
    // checks
    // ************************************************************
    sequence sLockedWrite(logic [7:0] ofs);
        clkEn && locked && regWrEn && regAddr == ofs;
    endsequence

    sequence sUnlockedTestWrite;
        clkEn && !locked && regWrEn && regAddr == OFS_SCAN_TEST_CONTROL;
    endsequence

    sequence sLockedMarginWrite;
        clkEn && locked && regWrEn &&
        (regAddr == OFS_ZONE12_TURNOFF_MARGIN || regAddr == OFS_ZONE3_TURNOFF_MARGIN);
    endsequence

    a_lock_sticky: assert property (@(posedge clk_sys) disable iff (!resetn)
        lockSticky_q |=> lockSticky_q)
        else $error("lock cleared without reset");
    a_locked_limit: assert property (@(posedge clk_sys) disable iff (!resetn)
        sLockedWrite(OFS_ZONE2_FULL_SPEED_LIMIT) |=> $stable(fullLimit_q[1]))
        else $error("locked limit changed");
    a_locked_test: assert property (@(posedge clk_sys) disable iff (!resetn)
        sLockedWrite(OFS_SCAN_TEST_CONTROL) |=> $stable(xorTreeEnable_q))
        else $error("locked test register changed");
    a_test_entry: assert property (@(posedge clk_sys) disable iff (!resetn)
        sUnlockedTestWrite |=> (xorTreeEnable_q == $past(wrXen)))
        else $error("test enable not written");
    a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clkEn && regRdEn && regAddr == OFS_ZONE3_TURNOFF_MARGIN) |=> regRdData_q[3:0] == 4'h0)
        else $error("reserved margin bits not zero");
    a_start_default: assert property (@(posedge clk_sys) disable iff (!resetn)
        !startIn |-> (effOn[0] == RST_FAN_ON_LIMIT && effFull[2] == RST_FULL_SPEED_LIMIT
                      && !xorTestMode))
        else $error("control not at defaults before start");
    a_full_duty: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clkEn && autoFanMode && |zoneOverTemp) |=> forceFullDuty_q)
        else $error("full duty not forced");
    a_no_full_manual: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clkEn && !autoFanMode) |=> !forceFullDuty_q)
        else $error("full duty forced outside auto mode");

    a_locked_margin: assert property (@(posedge clk_sys) disable iff (!resetn)
        sLockedMarginWrite |=> ($stable(margin12_q) && $stable(margin3_q)))
        else $error("locked margin changed");
    a_locked_on_limit: assert property (@(posedge clk_sys) disable iff (!resetn)
        sLockedWrite(OFS_ZONE1_FAN_ON_LIMIT) |=> $stable(onLimit_q[0]))
        else $error("locked on limit changed");
    a_margin_write: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clkEn && wrMargin3) |=> (margin3_q == $past(regWrData[ZONE3_MARGIN_LSB +: MARGIN_WIDTH])))
        else $error("zone 3 margin not written");
    a_full_write: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clkEn && wrOk && regAddr == OFS_ZONE1_FULL_SPEED_LIMIT)
        |=> fullLimit_q[0] == $past(regWrData))
        else $error("full speed limit not written");
    a_unmapped_read: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clkEn && regRdEn && regAddr > OFS_SCAN_TEST_CONTROL) |=> regRdData_q == READ_UNMAPPED)
        else $error("unmapped read not zero");
    a_clken_freeze: assert property (@(posedge clk_sys) disable iff (!resetn)
        !clkEn |=> ($stable(regRdData_q) && $stable(margin12_q) && $stable(forceFullDuty_q)))
        else $error("state moved while clock disabled");

endmodule // fan_zone_thermal_limits

`default_nettype wire

// File: design/fztl_pkg.sv
// fztl_pkg: register map, reset values and field positions of the fan zone limit bank
// assumes an 8-bit register address space driven by the management bus slave
`default_nettype none

package fztl_pkg;

    // ************************************************************
    // counts
    // ************************************************************
    localparam int unsigned NUM_ZONES = 3;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFS_ZONE1_FAN_ON_LIMIT     = 8'h67;
    localparam logic [7:0] OFS_ZONE2_FAN_ON_LIMIT     = 8'h68;
    localparam logic [7:0] OFS_ZONE3_FAN_ON_LIMIT     = 8'h69;
    localparam logic [7:0] OFS_ZONE1_FULL_SPEED_LIMIT = 8'h6A;
    localparam logic [7:0] OFS_ZONE2_FULL_SPEED_LIMIT = 8'h6B;
    localparam logic [7:0] OFS_ZONE3_FULL_SPEED_LIMIT = 8'h6C;
    localparam logic [7:0] OFS_ZONE12_TURNOFF_MARGIN  = 8'h6D;
    localparam logic [7:0] OFS_ZONE3_TURNOFF_MARGIN   = 8'h6E;
    localparam logic [7:0] OFS_SCAN_TEST_CONTROL      = 8'h6F;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_FAN_ON_LIMIT     = 8'h5A;
    localparam logic [7:0] RST_FULL_SPEED_LIMIT = 8'h64;
    localparam logic [7:0] RST_ZONE12_MARGIN    = 8'h44;
    localparam logic [7:0] RST_ZONE3_MARGIN     = 8'h40;
    localparam logic [7:0] RST_SCAN_TEST        = 8'h00;
    localparam logic [7:0] READ_UNMAPPED        = 8'h00;

    // ************************************************************
    // field positions and special codes
    // ************************************************************
    localparam int unsigned ZONE1_MARGIN_LSB   = 4;
    localparam int unsigned ZONE2_MARGIN_LSB   = 0;
    localparam int unsigned ZONE3_MARGIN_LSB   = 4;
    localparam int unsigned MARGIN_WIDTH       = 4;
    localparam int unsigned XOR_TREE_ENABLE_BIT = 0;
    localparam logic [7:0] FULL_SPEED_DISABLED = 8'h80;

endpackage : fztl_pkg

`default_nettype wire

// File: design/fztl_zone.sv
// fztl_zone: per-zone fan on/off decision with turn-off margin and full speed trip
// assumes temperature and limits are signed 8-bit values synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none

module fztl_zone
    import fztl_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       clkEn,
    input  wire logic [7:0] zoneTemp,
    input  wire logic [7:0] onLimit,
    input  wire logic [7:0] fullLimit,
    input  wire logic [3:0] margin,
    output logic            fanOn,
    output logic            rampUp,
    output logic            holdMin,
    output logic            overTemp
);

    typedef enum logic {ZS_OFF, ZS_RUN} fztl_zstate_t;

    fztl_zstate_t state_q;
    fztl_zstate_t state_d;
    logic         fanOn_q;
    logic         rampUp_q;
    logic         holdMin_q;
    logic         overTemp_q;

    // ************************************************************
    // signed compares
    // ************************************************************
    wire logic signed [9:0] tempX     = {{2{zoneTemp[7]}}, zoneTemp};
    wire logic signed [9:0] limitX    = {{2{onLimit[7]}}, onLimit};
    wire logic signed [9:0] offThresh = limitX - $signed({6'h00, margin});
    wire logic              atOrAbove = tempX >= limitX;
    wire logic              aboveLim  = tempX > limitX;
    wire logic              belowLim  = tempX < limitX;
    wire logic              belowOff  = tempX < offThresh;
    wire logic              tripFull  = (fullLimit != FULL_SPEED_DISABLED) &&
                                        ($signed(zoneTemp) > $signed(fullLimit));

    always_comb begin
        state_d = state_q;
        case (state_q)
            ZS_OFF:  if (atOrAbove) state_d = ZS_RUN;
            ZS_RUN:  if (belowOff) state_d = ZS_OFF;
            default: state_d = ZS_OFF;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q    <= ZS_OFF;
            fanOn_q    <= 1'b0;
            rampUp_q   <= 1'b0;
            holdMin_q  <= 1'b0;
            overTemp_q <= 1'b0;
        end else if (clkEn) begin
            state_q    <= state_d;
            fanOn_q    <= state_d == ZS_RUN;
            rampUp_q   <= (state_d == ZS_RUN) && aboveLim;
            holdMin_q  <= (state_d == ZS_RUN) && belowLim;
            overTemp_q <= tripFull;
        end
    end

    assign fanOn    = fanOn_q;
    assign rampUp   = rampUp_q;
    assign holdMin  = holdMin_q;
    assign overTemp = overTemp_q;

    // ************************************************************
    // checks
    // ************************************************************
    sequence sHoldCause;
        clkEn && state_q == ZS_RUN && belowLim && !belowOff;
    endsequence

    a_turn_on_equal: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clkEn && state_q == ZS_OFF && zoneTemp == onLimit) |=> fanOn_q)
        else $error("fan not on at limit");
    a_ramp_above: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clkEn && aboveLim) |=> (rampUp_q && fanOn_q && !holdMin_q))
        else $error("no ramp above limit");
    a_hold_min_band: assert property (@(posedge clk_sys) disable iff (!resetn)
        sHoldCause |=> (fanOn_q && holdMin_q && !rampUp_q))
        else $error("fan not held at minimum");
    a_turn_off_margin: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clkEn && belowOff && !atOrAbove) |=> !fanOn_q)
        else $error("fan not off below margin");
    a_abs_disabled: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clkEn && fullLimit == FULL_SPEED_DISABLED) |=> !overTemp_q)
        else $error("disabled zone tripped");

endmodule // fztl_zone

`default_nettype wire

// File: design/fztl_xor_tree.sv
// fztl_xor_tree: parity tree over the test pins for board connectivity test
// assumes the management bus pins are not part of testPins
`timescale 1ns/1ps
`default_nettype none

module fztl_xor_tree
    import fztl_pkg::*;
#(
    parameter int unsigned NUM_TEST_PINS = 16
)
(
    input  wire logic                     clk_sys,
    input  wire logic                     resetn,
    input  wire logic                     clkEn,
    input  wire logic                     treeEnable,
    input  wire logic [NUM_TEST_PINS-1:0] testPins,
    output logic                          treeOut
);

    logic treeOut_q;

    generate
        if (NUM_TEST_PINS < 1) begin : g_bad
            $error("fztl_xor_tree needs at least one test pin");
        end
    endgenerate

    // ************************************************************
    // tree
    // ************************************************************
    wire logic parity = ^testPins;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            treeOut_q <= 1'b0;
        end else if (clkEn) begin
            treeOut_q <= treeEnable & parity;
        end
    end

    assign treeOut = treeOut_q;

    a_tree_off: assert property (@(posedge clk_sys) disable iff (!resetn)
        (clkEn && !treeEnable) |=> !treeOut_q)
        else $error("tree output active while disabled");

endmodule // fztl_xor_tree

`default_nettype wire

// File: tb/fztl_lockstart_model.sv
// fztl_lockstart_model: lock/start control register beside the limit bank
// assumes the bench raises setLock and startReq as levels after a clock edge
`timescale 1ns/1ps
`default_nettype none

module fztl_lockstart_model (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic setLock,
    input  wire logic startReq,
    input  wire logic dropLock,
    output logic      lockOut,
    output logic      startOut
);
    // ************************************************************
    // lock sticky until dropLock or reset, start follows request
    // ************************************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lockOut  <= 1'b0;
            startOut <= 1'b0;
        end else begin
            lockOut  <= (lockOut | setLock) & ~dropLock;
            startOut <= startReq;
        end
    end
endmodule // fztl_lockstart_model

`default_nettype wire

// File: tb/fan_zone_thermal_limits_test.sv
// fan_zone_thermal_limits_test: self-checking bench of the fan zone limit bank
// assumes fztl_pkg, the design and the lock/start model are compiled first
`timescale 1ns/1ps
`default_nettype none

module fan_zone_thermal_limits_test
    import fztl_pkg::*;
();
    // ************************************************************
    // signals, design and partner
    // ************************************************************
    logic        clk_sys, resetn, clkEn, regWrEn, regRdEn, autoFanMode;
    logic [7:0]  regAddr, regWrData, regRdData;
    logic [7:0]  tmp [3];
    logic [15:0] testPins;
    logic [2:0]  fanOn, fanRampUp, fanHoldMin, zoneOverTemp, onM, rampM, holdM, overM;
    logic        forceFullDuty, xorTestMode, xorTreeOut;
    logic        lockIn, startIn, setLock, startReq, dropLock, lockedM;
    logic [7:0]  mdl [10];
    logic [31:0] rng;
    int          miscompares, num_checks, cyc;

    fan_zone_thermal_limits dut (.clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .lockIn(lockIn), .startIn(startIn),
        .autoFanMode(autoFanMode), .zoneTemp1(tmp[0]), .zoneTemp2(tmp[1]),
        .zoneTemp3(tmp[2]), .testPins(testPins), .fanOn(fanOn), .fanRampUp(fanRampUp),
        .fanHoldMin(fanHoldMin), .zoneOverTemp(zoneOverTemp),
        .forceFullDuty(forceFullDuty), .xorTestMode(xorTestMode), .xorTreeOut(xorTreeOut));
    fztl_lockstart_model host (.clk_sys(clk_sys), .resetn(resetn), .setLock(setLock),
        .startReq(startReq), .dropLock(dropLock), .lockOut(lockIn), .startOut(startIn));

    // ************************************************************
    // helpers and reference model
    // ************************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] eff(input int k);
        logic [7:0] rstv [10];
        rstv = '{8'h5A, 8'h5A, 8'h5A, 8'h64, 8'h64, 8'h64, 8'h44, 8'h40, 8'h00, 8'h00};
        return startIn ? mdl[k] : rstv[k];
    endfunction
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic wr(input int i, input logic [7:0] d);
        regAddr = 8'h67 + 8'(i);
        regWrData = d;
        regWrEn = 1'b1;
        step();
        regWrEn = 1'b0;
        step();
        if (i < 9 && !lockedM) mdl[i] = d & (i == 7 ? 8'hF0 : i == 8 ? 8'h01 : 8'hFF);
    endtask
    task automatic rd(input int i);
        regAddr = 8'h67 + 8'(i);
        regRdEn = 1'b1;
        step();
        regRdEn = 1'b0;
        step();
        chk(regRdData, mdl[i], "register read");
    endtask
    task automatic burst();
        for (int i = 0; i < 10; i++) begin
            rng = xs(rng);
            wr(i, rng[7:0]);
        end
        for (int i = 0; i < 10; i++) rd(i);
    endtask
    task automatic zeval();
        for (int i = 0; i < 3; i++) begin
            int l, f, m, t;
            logic [7:0] h;
            l = $signed(eff(i));
            f = $signed(eff(3 + i));
            h = eff(6 + i / 2);
            m = (i == 1) ? int'(h[3:0]) : int'(h[7:4]);
            t = $signed(tmp[i]);
            if (t >= l) onM[i] = 1'b1;
            else if (t < l - m) onM[i] = 1'b0;
            rampM[i] = onM[i] && t > l;
            holdM[i] = onM[i] && t < l;
            overM[i] = t > f && eff(3 + i) != 8'h80;
        end
    endtask
    task automatic cmp();
        zeval();
        chk({5'b0, fanOn}, {5'b0, onM}, "fan on");
        chk({5'b0, fanRampUp}, {5'b0, rampM}, "ramp up");
        chk({5'b0, fanHoldMin}, {5'b0, holdM}, "hold minimum");
        chk({5'b0, zoneOverTemp}, {5'b0, overM}, "over temperature");
        chk({7'b0, forceFullDuty}, {7'b0, autoFanMode & |overM}, "full duty");
    endtask
    task automatic zones(input int n);
        int t;
        zeval();
        for (int k = 0; k < n; k++) begin
            for (int i = 0; i < 3; i++) begin
                rng = xs(rng);
                t = $signed(eff(i)) + int'(rng[4:0]) - 16;
                tmp[i] = 8'(t > 127 ? 127 : t < -128 ? -128 : t);
            end
            autoFanMode = rng[8];
            repeat (3) step();
            cmp();
        end
    endtask
    task automatic stop_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ************************************************************
    // clock, timeout and main sequence
    // ************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            $display("CHECK FAILED t=%0t timeout", $time);
            stop_test();
        end
    end
    initial begin
        {resetn, regWrEn, regRdEn, autoFanMode, setLock, startReq, dropLock, lockedM} = '0;
        clkEn = 1'b1;
        regAddr = 8'h00;
        regWrData = 8'h00;
        testPins = 16'h0000;
        tmp = '{8'h00, 8'h00, 8'h00};
        onM = 3'b000;
        rng = 32'h0000_4F3D;
        mdl = '{8'h5A, 8'h5A, 8'h5A, 8'h64, 8'h64, 8'h64, 8'h44, 8'h40, 8'h00, 8'h00};
        repeat (20) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        step();
        for (int i = 0; i < 10; i++) rd(i);
        zones(20);
        burst();
        zones(20);
        startReq = 1'b1;
        repeat (2) step();
        zones(80);
        wr(3, 8'h80);
        tmp[0] = 8'h7F;
        autoFanMode = 1'b1;
        repeat (3) step();
        cmp();
        rng = xs(rng);
        testPins = {rng[15:1], ~^rng[15:1]};
        wr(8, 8'hFF);
        step();
        chk({7'b0, xorTreeOut}, {7'b0, ^testPins}, "xor tree");
        chk({7'b0, xorTestMode}, 8'h01, "test mode on");
        wr(8, 8'h00);
        step();
        chk({7'b0, xorTreeOut}, 8'h00, "xor tree off");
        wr(8, 8'h01);
        setLock = 1'b1;
        step();
        setLock = 1'b0;
        lockedM = 1'b1;
        burst();
        chk({7'b0, xorTestMode}, 8'h01, "test mode held");
        dropLock = 1'b1;
        step();
        burst();
        clkEn = 1'b0;
        regAddr = 8'h6F;
        regRdEn = 1'b1;
        step();
        {clkEn, regRdEn} = 2'b10;
        step();
        chk(regRdData, mdl[9], "read while clock disabled");
        zones(20);
        stop_test();
    end
endmodule // fan_zone_thermal_limits_test

`default_nettype wire
